/* File: hw/rtceo_regs.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes an APB slave with byte addresses on an 8-bit window
`ifndef RTCEO_REGS_SVH
`define RTCEO_REGS_SVH
// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define RTCEO_OFS_CTRL 8'h00
`define RTCEO_OFS_STAT 8'h04
`define RTCEO_OFS_FREQ 8'h08
`define RTCEO_OFS_ALM1 8'h0C
`define RTCEO_OFS_ALM2 8'h10
`define RTCEO_OFS_TRIM 8'h14
// ---------------------------------------------------------------
// Control bits
// ---------------------------------------------------------------
`define RTCEO_CB_A1 0
`define RTCEO_CB_ME 1
`define RTCEO_CB_FE 2
`define RTCEO_CB_XE 3
`define RTCEO_CB_A2 4
`define RTCEO_CB_P1 5
`define RTCEO_CB_P2 6
`define RTCEO_CTRL_W 7
// Power-up: frequency output mode, 1 Hz selected
`define RTCEO_CTRL_RST 7'h04
`define RTCEO_FREQ_RST 5'h10
// Frequency select sits in write data bits 7..3
`define RTCEO_FREQ_LO 3
`define RTCEO_FREQ_HI 7
// Lowest divider bit used by the frequency select (16 Hz)
`define RTCEO_FREQ_DIV_LO 10
// Status bits
`define RTCEO_SB_POWERUP 0
`define RTCEO_SB_PIN 1
`define RTCEO_SB_AL1 2
`define RTCEO_SB_AL2 3
// Alarm word fields
`define RTCEO_AF_MIN_HI 6
`define RTCEO_AF_HR_LO 8
`define RTCEO_AF_HR_HI 13
`define RTCEO_AF_WD_LO 16
`define RTCEO_AF_WD_HI 18
`define RTCEO_AF_ME 24
`define RTCEO_AF_HE 25
`define RTCEO_AF_WE 26
// ---------------------------------------------------------------
// Timing, counted in 32.768 kHz ticks or in whole seconds
// ---------------------------------------------------------------
`define RTCEO_XTAL_HZ 32768
`define RTCEO_EDGE_US 7810
`define RTCEO_EDGE_TICKS (((`RTCEO_EDGE_US*`RTCEO_XTAL_HZ)+999999)/1000000)
`define RTCEO_DEFER_MS 500
`define RTCEO_DEFER_TICKS ((`RTCEO_DEFER_MS*`RTCEO_XTAL_HZ)/1000)
`define RTCEO_DIV_MAX 15'h7FFF
`define RTCEO_IVL_COARSE 20
`define RTCEO_IVL_FINE 60
`define RTCEO_STEP_TICKS 2
`define RTCEO_TRIM_FULL 128
`define RTCEO_HALF_MIN 30
`endif

/* File: hw/rtceo_pkg.sv */
// Types shared by the event output block and its divider
// Assumes calendar fields arrive in binary from same-clock logic
package rtceo_pkg;
	// Current time as seen by the comparators
	typedef struct packed {
		logic [2:0] weekday;
		logic [5:0] hour;
		logic [6:0] minute;
	} rtceo_time_t;
	// One alarm: per-field enables and values
	typedef struct packed {
		logic weekday_match_enable;
		logic hour_match_enable;
		logic minute_match_enable;
		logic [2:0] weekday;
		logic [5:0] hour;
		logic [6:0] minute;
	} rtceo_alarm_t;
	// Source that currently drives the event pin
	typedef enum logic [2:0] {
		RTCEO_SRC_IDLE, RTCEO_SRC_XTAL, RTCEO_SRC_FREQ, RTCEO_SRC_EDGE,
		RTCEO_SRC_PER1, RTCEO_SRC_PER2, RTCEO_SRC_ALM1
	} rtceo_src_t;
endpackage

/* File: hw/rtceo_div.sv */
// Trimmed divider: 32.768 kHz ticks down to the 1 Hz second
// Assumes xtal_tick is a one-cycle pulse already on pclk
`timescale 1ns/1ps
`include "rtceo_regs.svh"
module rtceo_div (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic xtal_tick,
	input wire logic [7:0] trim,
	input wire logic restart,
	output logic [14:0] div,
	output logic sec_tick
);
	import rtceo_pkg::*;
	logic [6:0] step; // Trim value with bit order restored
	logic [7:0] stall; // Extra ticks still to swallow
	logic [5:0] ivl; // Seconds within the trim interval
	logic [7:0] next_stall;
	logic [14:0] next_div;
	logic [5:0] next_ivl;
	logic next_sec;
	logic ivl_end;
	// ---------------------------------------------------------------
	// Trim decode
	// ---------------------------------------------------------------
	// Stored bit-reversed: register bit 7 is the step's lsb
	for (genvar i = 0; i < 7; i++) begin : g_rev
		assign step[i] = trim[7 - i];
	end
	// Bit 0 picks the 60 s fine interval, else 20 s coarse
	assign ivl_end = trim[0] ? (ivl == 6'(`RTCEO_IVL_FINE - 1))
		: (ivl == 6'(`RTCEO_IVL_COARSE - 1));
	// ---------------------------------------------------------------
	// Divider next state
	// ---------------------------------------------------------------
	// Only the divider is touched; the crystal keeps its rate
	always_comb begin
		next_div = div;
		next_stall = stall;
		next_ivl = ivl;
		next_sec = 1'b0;
		if (restart) begin
			// A time write restarts the second
			next_div = '0;
			next_stall = '0;
		end else if (xtal_tick) begin
			if (stall != 8'h00) begin
				next_stall = stall - 8'h01;
			end else if (div == `RTCEO_DIV_MAX) begin
				next_sec = 1'b1;
				next_div = '0;
				next_ivl = ivl_end ? 6'h00 : ivl + 6'h01;
				if (ivl_end && step != 7'h00) begin
					if (!step[6]) begin
						// Fast: skip two ticks per step, 3.052 or 1.017 ppm
						next_div = 15'(step * `RTCEO_STEP_TICKS);
					end else begin
						// Slow: hold for two ticks per (128 - step)
						next_stall = 8'((`RTCEO_TRIM_FULL - step)
							* `RTCEO_STEP_TICKS);
					end
				end
			end else begin
				next_div = div + 15'h0001;
			end
		end
	end
	// Register the divider state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= '0;
			stall <= '0;
			ivl <= '0;
			sec_tick <= 1'b0;
		end else begin
			div <= next_div;
			stall <= next_stall;
			ivl <= next_ivl;
			sec_tick <= next_sec;
		end
	end
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_stall_holds: assert property (stall != 8'h00 && !restart
		|=> div == $past(div))
		else $error("divider moved while stalling");
	a_fast_jump: assert property (xtal_tick && !restart && stall == 8'h00
		&& div == `RTCEO_DIV_MAX && ivl_end && step != 7'h00 && !step[6]
		|=> div == 15'(step * `RTCEO_STEP_TICKS) && sec_tick)
		else $error("fast trim did not skip ticks");
	c_slow_trim: cover property (stall == 8'h80);
endmodule // rtceo_div

/* File: hw/rtceo_event.sv */
// Event pin output modes with rate trim and APB registers
// Assumes calendar logic on pclk supplies time and minute carry
// Behaviour
// - Enabled alarm match drives pin low
// - Re-enable within match period gives no alarm
// - Per-field enables choose compared fields
// - Hour-only re-enable fires at next minute
// - Frequency mode outputs AND of selections
// - Minute edge low until enable cleared
// - Edge event lasts 7.81 ms, re-enable relowers
// - Periodic 1: one-minute 50% square wave
// - Periodic 1 disable forces high, re-enable lowers
// - Periodic 2: 7.81 ms low each carry
// - Reads postpone carry at most 0.5 s
// - Time writes may shift periodic pulse
// - Power-on sets flag, outputs 1 Hz
// - Trim on divider every 20 or 60 s
// - Step 3.052 ppm coarse, 1.017 ppm fine
// - Span -195.3..+192.2 or -65.1..+64.1 ppm
// - Trim value bit-reversed, slow uses 128-n
// - Alarm 2 lowers pin in any mode
// - Bits 7..3 each select one frequency
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "rtceo_regs.svh"
module rtceo_event (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_32k,
	input wire rtceo_pkg::rtceo_time_t rt_time,
	input wire logic minute_carry,
	input wire logic rt_read_active,
	input wire logic rt_write,
	output logic sec_tick,
	output logic event_n
);
	import rtceo_pkg::*;
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [6:0] ctrl, next_ctrl; // Mode enables
	logic powerup_flag, next_powerup; // Set only by reset
	logic [4:0] freqsel, next_freqsel; // Frequency selection
	rtceo_alarm_t alm1, alm2, next_alm1, next_alm2;
	logic [7:0] trim, next_trim; // Rate trim setting
	logic [31:0] next_prdata;
	logic [2:0] osc_sync; // Two-stage sync plus edge history
	logic xtal_tick;
	logic [14:0] div;
	logic addr_ok, wr_acc, rd_setup;
	logic carry_pend, next_pend; // Minute carry awaiting release
	logic [14:0] defer, next_defer; // Ticks spent waiting
	logic carry_go, carry_evt; // Carry released to the modes
	logic [8:0] edge_cnt, next_edge_cnt; // 7.81 ms event window
	logic window;
	logic [5:0] sec_since, next_sec_since; // Seconds since carry
	logic p1_armed, next_p1_armed, p1_low;
	logic p2_low, next_p2_low, edge_low, next_edge_low;
	logic al1_low, next_al1_low, al2_low, next_al2_low;
	logic match1, match2;
	logic [4:0] freq_and;
	rtceo_src_t src;
	logic next_event_n;
	// ---------------------------------------------------------------
	// Crystal input sync and divider
	// ---------------------------------------------------------------
	// Pin comes from another clock: two flops before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_sync <= '0;
		end else begin
			osc_sync <= {osc_sync[1:0], osc_32k};
		end
	end
	assign xtal_tick = osc_sync[1] & ~osc_sync[2];
	// Trimmed divider; the second restarts on a time write
	rtceo_div u_div (
		.pclk(pclk),
		.presetn(presetn),
		.xtal_tick(xtal_tick),
		.trim(trim),
		.restart(rt_write),
		.div(div),
		.sec_tick(sec_tick)
	);
	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	// Zero wait states; read data captured in the setup cycle
	assign pready = 1'b1;
	assign addr_ok = paddr == `RTCEO_OFS_CTRL || paddr == `RTCEO_OFS_STAT
		|| paddr == `RTCEO_OFS_FREQ || paddr == `RTCEO_OFS_ALM1
		|| paddr == `RTCEO_OFS_ALM2 || paddr == `RTCEO_OFS_TRIM;
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_acc = psel & penable & pwrite & addr_ok;
	assign rd_setup = psel & ~penable & ~pwrite;
	// Register writes and read capture
	always_comb begin
		next_ctrl = ctrl;
		next_powerup = powerup_flag;
		next_freqsel = freqsel;
		next_alm1 = alm1;
		next_alm2 = alm2;
		next_trim = trim;
		next_prdata = prdata;
		if (wr_acc) begin
			if (paddr == `RTCEO_OFS_CTRL) begin
				next_ctrl = pwdata[`RTCEO_CTRL_W-1:0];
			end else if (paddr == `RTCEO_OFS_STAT) begin
				// Init clears the flag and leaves 1 Hz mode
				if (pwdata[`RTCEO_SB_POWERUP]) begin
					next_powerup = 1'b0;
					next_ctrl = '0;
					next_freqsel = '0;
					next_trim = '0;
				end
			end else if (paddr == `RTCEO_OFS_FREQ) begin
				next_freqsel = pwdata[`RTCEO_FREQ_HI:`RTCEO_FREQ_LO];
			end else if (paddr == `RTCEO_OFS_ALM1) begin
				next_alm1 = {pwdata[`RTCEO_AF_WE], pwdata[`RTCEO_AF_HE],
					pwdata[`RTCEO_AF_ME],
					pwdata[`RTCEO_AF_WD_HI:`RTCEO_AF_WD_LO],
					pwdata[`RTCEO_AF_HR_HI:`RTCEO_AF_HR_LO],
					pwdata[`RTCEO_AF_MIN_HI:0]};
			end else if (paddr == `RTCEO_OFS_ALM2) begin
				next_alm2 = {pwdata[`RTCEO_AF_WE], pwdata[`RTCEO_AF_HE],
					pwdata[`RTCEO_AF_ME],
					pwdata[`RTCEO_AF_WD_HI:`RTCEO_AF_WD_LO],
					pwdata[`RTCEO_AF_HR_HI:`RTCEO_AF_HR_LO],
					pwdata[`RTCEO_AF_MIN_HI:0]};
			end else begin
				next_trim = pwdata[7:0];
			end
		end
		if (rd_setup) begin
			next_prdata = '0;
			if (paddr == `RTCEO_OFS_CTRL) begin
				next_prdata[`RTCEO_CTRL_W-1:0] = ctrl;
			end else if (paddr == `RTCEO_OFS_STAT) begin
				// Live state of the block
				next_prdata[`RTCEO_SB_POWERUP] = powerup_flag;
				next_prdata[`RTCEO_SB_PIN] = event_n;
				next_prdata[`RTCEO_SB_AL1] = al1_low;
				next_prdata[`RTCEO_SB_AL2] = al2_low;
			end else if (paddr == `RTCEO_OFS_FREQ) begin
				next_prdata[`RTCEO_FREQ_HI:`RTCEO_FREQ_LO] = freqsel;
			end else if (paddr == `RTCEO_OFS_ALM1) begin
				next_prdata = {5'h00, alm1.weekday_match_enable,
					alm1.hour_match_enable, alm1.minute_match_enable,
					5'h00, alm1.weekday, 2'h0, alm1.hour, 1'b0, alm1.minute};
			end else if (paddr == `RTCEO_OFS_ALM2) begin
				next_prdata = {5'h00, alm2.weekday_match_enable,
					alm2.hour_match_enable, alm2.minute_match_enable,
					5'h00, alm2.weekday, 2'h0, alm2.hour, 1'b0, alm2.minute};
			end else if (paddr == `RTCEO_OFS_TRIM) begin
				next_prdata[7:0] = trim;
			end
		end
	end
	// Power-up values: flag set, 1 Hz frequency output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `RTCEO_CTRL_RST;
			powerup_flag <= 1'b1;
			freqsel <= `RTCEO_FREQ_RST;
			alm1 <= '0;
			alm2 <= '0;
			trim <= '0;
			prdata <= '0;
		end else begin
			ctrl <= next_ctrl;
			powerup_flag <= next_powerup;
			freqsel <= next_freqsel;
			alm1 <= next_alm1;
			alm2 <= next_alm2;
			trim <= next_trim;
			prdata <= next_prdata;
		end
	end
	// ---------------------------------------------------------------
	// Minute events
	// ---------------------------------------------------------------
	// A disabled field always matches; no field enabled never does
	function automatic logic alarm_hit(rtceo_alarm_t a, rtceo_time_t t);
		alarm_hit = (a.weekday_match_enable | a.hour_match_enable
			| a.minute_match_enable)
			& (~a.weekday_match_enable | a.weekday == t.weekday)
			& (~a.hour_match_enable | a.hour == t.hour)
			& (~a.minute_match_enable | a.minute == t.minute);
	endfunction
	assign match1 = alarm_hit(alm1, rt_time);
	assign match2 = alarm_hit(alm2, rt_time);
	// Reads hold the carry back, but never past half a second
	assign carry_go = carry_pend & (~rt_read_active
		| defer >= 15'(`RTCEO_DEFER_TICKS));
	assign window = edge_cnt != 9'h000;
	// Alarms are judged only at a carry, so a re-enable inside the
	// same minute cannot fire; an hour-only alarm fires next minute
	always_comb begin
		next_pend = carry_pend;
		next_defer = defer;
		if (minute_carry) begin
			next_pend = 1'b1;
			next_defer = '0;
		end else if (carry_go) begin
			next_pend = 1'b0;
		end else if (carry_pend && xtal_tick) begin
			next_defer = defer + 15'h0001;
		end
		next_edge_cnt = edge_cnt;
		if (carry_evt) begin
			next_edge_cnt = 9'(`RTCEO_EDGE_TICKS);
		end else if (window && xtal_tick) begin
			next_edge_cnt = edge_cnt - 9'h001;
		end
		next_sec_since = sec_since;
		if (carry_evt) begin
			next_sec_since = '0;
		end else if (sec_tick && sec_since != 6'h3F) begin
			next_sec_since = sec_since + 6'h01;
		end
		// Arming follows the enable at each carry only
		next_p1_armed = carry_evt ? ctrl[`RTCEO_CB_P1] : p1_armed;
		next_p2_low = ctrl[`RTCEO_CB_P2] & (carry_evt
			| (p2_low & window));
		next_edge_low = ctrl[`RTCEO_CB_ME] & (edge_low | carry_evt
			| window);
		// Set wins over the enable clear in the same cycle
		next_al1_low = (carry_evt & ctrl[`RTCEO_CB_A1] & match1)
			| (al1_low & next_ctrl[`RTCEO_CB_A1]);
		next_al2_low = (carry_evt & ctrl[`RTCEO_CB_A2] & match2)
			| (al2_low & next_ctrl[`RTCEO_CB_A2]);
	end
	// Register the minute event state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_pend <= 1'b0;
			defer <= '0;
			carry_evt <= 1'b0;
			edge_cnt <= '0;
			sec_since <= '0;
			p1_armed <= 1'b0;
			p2_low <= 1'b0;
			edge_low <= 1'b0;
			al1_low <= 1'b0;
			al2_low <= 1'b0;
		end else begin
			carry_pend <= next_pend;
			defer <= next_defer;
			carry_evt <= carry_go;
			edge_cnt <= next_edge_cnt;
			sec_since <= next_sec_since;
			p1_armed <= next_p1_armed;
			p2_low <= next_p2_low;
			edge_low <= next_edge_low;
			al1_low <= next_al1_low;
			al2_low <= next_al2_low;
		end
	end
	// ---------------------------------------------------------------
	// Pin selection
	// ---------------------------------------------------------------
	// Each selected divider tap joins the AND; unselected ones pass
	for (genvar i = 0; i < 5; i++) begin : g_freq
		assign freq_and[i] = ~freqsel[i]
			| div[`RTCEO_FREQ_DIV_LO + i];
	end
	// Low for the first half of each minute, while enabled
	assign p1_low = ctrl[`RTCEO_CB_P1] & p1_armed
		& (sec_since < 6'(`RTCEO_HALF_MIN));
	// Fixed priority when several modes are enabled at once
	always_comb begin
		if (ctrl[`RTCEO_CB_XE]) begin
			src = RTCEO_SRC_XTAL;
		end else if (ctrl[`RTCEO_CB_FE]) begin
			src = RTCEO_SRC_FREQ;
		end else if (ctrl[`RTCEO_CB_ME]) begin
			src = RTCEO_SRC_EDGE;
		end else if (ctrl[`RTCEO_CB_P1]) begin
			src = RTCEO_SRC_PER1;
		end else if (ctrl[`RTCEO_CB_P2]) begin
			src = RTCEO_SRC_PER2;
		end else if (ctrl[`RTCEO_CB_A1]) begin
			src = RTCEO_SRC_ALM1;
		end else begin
			src = RTCEO_SRC_IDLE;
		end
		case (src)
			RTCEO_SRC_XTAL: next_event_n = osc_sync[1];
			RTCEO_SRC_FREQ: next_event_n = &freq_and;
			RTCEO_SRC_EDGE: next_event_n = ~edge_low;
			RTCEO_SRC_PER1: next_event_n = ~p1_low;
			RTCEO_SRC_PER2: next_event_n = ~p2_low;
			RTCEO_SRC_ALM1: next_event_n = ~al1_low;
			default: next_event_n = 1'b1;
		endcase
		// Alarm 2 overrides whatever mode is selected
		if (al2_low) begin
			next_event_n = 1'b0;
		end
	end
	// Pin register; high until the power-up 1 Hz starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_n <= 1'b1;
		end else begin
			event_n <= next_event_n;
		end
	end
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_alarm_fires: assert property (carry_evt && ctrl[`RTCEO_CB_A1]
		&& match1 |=> al1_low)
		else $error("alarm 1 match did not latch");
	a_no_refire: assert property (!al1_low && !carry_evt
		|=> !al1_low)
		else $error("alarm 1 latched without a carry");
	a_hour_only: assert property (alm1.hour_match_enable
		&& !alm1.weekday_match_enable && !alm1.minute_match_enable
		&& alm1.hour == rt_time.hour |-> match1)
		else $error("hour-only compare missed");
	a_edge_hold: assert property (carry_evt && ctrl[`RTCEO_CB_ME]
		&& $stable(ctrl) |=> edge_low
		##1 (!event_n || $past(ctrl) != $past(ctrl, 2)))
		else $error("minute edge did not lower pin");
	a_edge_release: assert property (!ctrl[`RTCEO_CB_ME]
		|=> !edge_low)
		else $error("minute edge held while disabled");
	a_per2_pulse: assert property (carry_evt && ctrl[`RTCEO_CB_P2]
		&& !rt_write ##1 ctrl[`RTCEO_CB_P2] |-> p2_low)
		else $error("periodic pulse missing");
	a_per1_off: assert property (!ctrl[`RTCEO_CB_P1] |-> !p1_low)
		else $error("periodic 1 low while disabled");
	a_defer_bound: assert property (carry_pend && !minute_carry
		&& defer >= 15'(`RTCEO_DEFER_TICKS) |=> carry_evt)
		else $error("carry postponed too long");
	a_alarm2_wins: assert property (al2_low |=> !event_n)
		else $error("alarm 2 did not lower pin");
	a_freq_and: assert property (src == RTCEO_SRC_FREQ && !al2_low
		|=> event_n == $past(&freq_and))
		else $error("frequency output wrong");
	c_alarm1: cover property (carry_evt && match1 ##1 !event_n);
	c_edge_reenable: cover property ($fell(edge_low) ##[1:8] edge_low);
	c_per1_high: cover property (p1_armed && $fell(p1_low));
	c_deferred: cover property ((carry_pend && rt_read_active)[*8]);
endmodule // rtceo_event

/* File: testbench/rtceo_host.sv */
// Host-side model: crystal source and a watcher on the event pin
// Assumes pclk at 100 MHz; the crystal is sped up to 25 MHz
`timescale 1ns/1ps
module rtceo_host (
	input wire logic pclk,
	input wire logic event_n,
	input wire logic clr,
	output logic osc_32k,
	output logic [15:0] high_cnt
);
	// ----------------------------------------------------------
	// Crystal
	// ----------------------------------------------------------
	// Sped up so that divider events fit a short run; the phase is
	// offset so that its edges never line up with pclk
	initial begin
		osc_32k = 1'b0;
		#3;
		forever #20 osc_32k = ~osc_32k;
	end
	// ----------------------------------------------------------
	// Pin watcher
	// ----------------------------------------------------------
	// Counts cycles with the pin high since the last clear
	always @(posedge pclk) begin
		if (clr) begin
			high_cnt <= 16'h0000;
		end else begin
			high_cnt <= high_cnt + {15'h0000, event_n};
		end
	end
endmodule // rtceo_host

/* File: testbench/rtceo_event_tb.sv */
// Bench for the event pin block: APB access tasks and pin checks
// Assumes the host model supplies the crystal and watches the pin
`timescale 1ns/1ps
`include "rtceo_regs.svh"
module rtceo_event_tb;
	import rtceo_pkg::*;
	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic osc_32k;
	rtceo_time_t rt_time = '0; // Calendar as the comparators see it
	logic minute_carry = 1'b0;
	logic rt_read_active = 1'b0; // Host reading the time registers
	logic rt_write = 1'b0; // Time write pulse; restarts the second
	logic sec_tick;
	logic event_n;
	logic clr = 1'b1; // Restarts the pin watcher
	logic [15:0] high_cnt;
	logic [31:0] q; // Read data of the last transfer
	logic e; // Error response of the last transfer
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	int secs = 0; // Second pulses seen; the run is shorter than one
	rtceo_event dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_32k(osc_32k), .rt_time(rt_time), .minute_carry(minute_carry),
		.rt_read_active(rt_read_active), .rt_write(rt_write),
		.sec_tick(sec_tick), .event_n(event_n));
	rtceo_host host (.pclk(pclk), .event_n(event_n), .clr(clr),
		.osc_32k(osc_32k), .high_cnt(high_cnt));
	always #5 pclk = ~pclk;
	// Hang guard: the sequence needs about 43000 cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		// Any second pulse, or an unknown, counts once out of reset
		if (presetn && sec_tick !== 1'b0) begin
			secs <= secs + 1;
		end
		if (cycles == 90000) begin
			miscompares = miscompares + 1;
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Calendar minute carry, then room for the pin to follow
	task automatic carry();
		@(posedge pclk);
		minute_carry <= 1'b1;
		@(posedge pclk);
		minute_carry <= 1'b0;
		waitc(6);
	endtask
	// Sample the pin after its edge updates have landed
	task automatic pin(input int n, input logic x);
		waitc(n);
		#1;
		chk({31'h0, event_n}, {31'h0, x});
	endtask
	task automatic watch(input int n);
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		waitc(n);
		#1;
	endtask
	// High time over one 8 Hz period of the crystal as sped up
	task automatic duty(input logic [31:0] f, input int lo, input int hi);
		apb(1'b1, `RTCEO_OFS_FREQ, f);
		watch(16384);
		chk({31'h0, high_cnt >= lo && high_cnt <= hi}, 32'h1);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Power-up: frequency mode at 1 Hz with the flag set
		apb(1'b0, `RTCEO_OFS_CTRL, 32'h0);
		chk(q, 32'h4);
		apb(1'b0, `RTCEO_OFS_FREQ, 32'h0);
		chk(q, 32'h80);
		apb(1'b0, `RTCEO_OFS_STAT, 32'h0);
		chk(q, 32'h1);
		// Unmapped place: error response and zero data
		apb(1'b0, 8'h20, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, `RTCEO_OFS_TRIM, 32'h56);
		apb(1'b0, `RTCEO_OFS_TRIM, 32'h0);
		chk(q, 32'h56);
		apb(1'b1, `RTCEO_OFS_TRIM, 32'hD8);
		apb(1'b1, `RTCEO_OFS_TRIM, 32'h0);
		// Initialise: flag and mode both cleared
		apb(1'b1, `RTCEO_OFS_STAT, 32'h1);
		apb(1'b0, `RTCEO_OFS_STAT, 32'h0);
		chk(q, 32'h2);
		pin(4, 1'b1);
		// Hour-only alarm 1 with the other modes off
		apb(1'b1, `RTCEO_OFS_ALM1, 32'h0200_0500);
		rt_time.hour <= 6'h05;
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h1);
		carry();
		pin(1, 1'b0);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h0);
		pin(4, 1'b1);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h1);
		pin(4, 1'b1);
		carry();
		pin(1, 1'b0);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h0);
		rt_time.hour <= 6'h06;
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h1);
		carry();
		pin(1, 1'b1);
		// Alarm 2 holds the pin low over a running frequency output
		apb(1'b1, `RTCEO_OFS_ALM2, 32'h0200_0600);
		apb(1'b1, `RTCEO_OFS_FREQ, 32'h08);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h14);
		carry();
		watch(3000);
		chk({16'h0, high_cnt}, 32'h0);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h0);
		pin(4, 1'b1);
		// Crystal passthrough: high for half of 400 cycles
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h8);
		watch(400);
		chk({16'h0, high_cnt}, 32'hC8);
		// Frequency output runs with the alarm 1 enable set
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h5);
		duty(32'h08, 8000, 8400);
		duty(32'h18, 3900, 4300);
		// A time write restarts the divider, so both taps stay low
		@(posedge pclk);
		rt_write <= 1'b1;
		@(posedge pclk);
		rt_write <= 1'b0;
		watch(3000);
		chk({16'h0, high_cnt}, 32'h0);
		// Minute edge: low from the carry until the enable is cleared
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h2);
		carry();
		pin(2000, 1'b0);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h0);
		pin(4, 1'b1);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h2);
		carry();
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h0);
		pin(2, 1'b1);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h2);
		pin(4, 1'b0);
		// Periodic 1: low half, then disable and re-enable
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h20);
		carry();
		pin(1, 1'b0);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h0);
		pin(4, 1'b1);
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h20);
		pin(4, 1'b0);
		// Periodic 2: one short low pulse per carry
		apb(1'b1, `RTCEO_OFS_CTRL, 32'h40);
		carry();
		pin(700, 1'b0);
		pin(700, 1'b1);
		// A time read holds the carry back until it ends
		@(posedge pclk);
		rt_read_active <= 1'b1;
		carry();
		pin(20, 1'b1);
		@(posedge pclk);
		rt_read_active <= 1'b0;
		pin(8, 1'b0);
		// Far less than one second of crystal ticks has passed
		chk(secs, 32'h0);
		tally_and_finish();
	end
endmodule // rtceo_event_tb
